//--- rtl/smfd_defs.vh
// Constants for the signal monitor fault display block.
`ifndef SMFD_DEFS_VH
`define SMFD_DEFS_VH

// ----------------------------------------------------------------
// Failure-mode legend codes
// ----------------------------------------------------------------
`define SMFD_MODE_W 4
`define SMFD_MODE_NONE 4'h0
`define SMFD_MODE_CONF 4'h1
`define SMFD_MODE_RED 4'h2
`define SMFD_MODE_CVM 4'h3
`define SMFD_MODE_24A 4'h4
`define SMFD_MODE_24B 4'h5
`define SMFD_MODE_CLEAR 4'h6
`define SMFD_MODE_WATCH 4'h7
`define SMFD_MODE_FAIL 4'h8

// ----------------------------------------------------------------
// Channel layout: three bits per channel (red, yellow, green)
// ----------------------------------------------------------------
`define SMFD_SIG_W 3
`define SMFD_SIG_RED 3'h4
`define SMFD_PANEL_CH 6

// ----------------------------------------------------------------
// Message screen codes and menu cursor positions
// ----------------------------------------------------------------
`define SMFD_SCR_W 3
`define SMFD_SCR_TIME 3'h0
`define SMFD_SCR_COUNT 3'h1
`define SMFD_SCR_MAIN 3'h2
`define SMFD_SCR_PROG 3'h3
`define SMFD_SCR_MSG 3'h4
`define SMFD_SCR_EVENT 3'h5
`define SMFD_CUR_W 2
`define SMFD_CUR_FIRST 2'h0
`define SMFD_CUR_ENTER 2'h1
`define SMFD_CUR_PRIOR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMFD_CLK_MHZ 250
`define SMFD_DEBOUNCE_US 10000
`define SMFD_FLASH_US 500000

`endif

//--- rtl/smfd_debounce.v
// Pushbutton synchroniser, debouncer and press pulse generator.
`timescale 1ns/100ps
module smfd_debounce #(
  parameter integer STABLE_CYCLES = 2500000
) (
  // Clock, reset and enable
  input wire mclk,
  input wire nrst,
  input wire ce,
  // Button pin and command pulse
  input wire button_n,
  output reg press
);

reg sync_a;
reg sync_b;
reg level;
reg [31:0] count;

always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    sync_a <= 1'b0;
    sync_b <= 1'b0;
    level <= 1'b0;
    count <= 32'h0;
    press <= 1'b0;
  end
  else if (ce)
  begin
    sync_a <= ~button_n;
    sync_b <= sync_a;
    press <= 1'b0;
    if (sync_b == level)
      count <= 32'h0;
    else if (count >= STABLE_CYCLES - 1)
    begin
      count <= 32'h0;
      level <= sync_b;
      press <= sync_b;
    end
    else
      count <= count + 32'h1;
  end
end

endmodule // smfd_debounce

//--- rtl/smfd_display.v
// Fault display, fault latch, message log and two-button menu of the monitor.
`timescale 1ns/100ps
`include "smfd_defs.vh"
module smfd_display #(
  parameter integer CHANNELS = 12,
  parameter integer LOG_DEPTH = 16,
  parameter integer LOG_AW = 4,
  parameter integer TIME_W = 32,
  parameter integer DEBOUNCE_CYCLES = `SMFD_DEBOUNCE_US * `SMFD_CLK_MHZ,
  parameter integer FLASH_CYCLES = `SMFD_FLASH_US * `SMFD_CLK_MHZ
) (
  // Clock, reset and enable
  input wire mclk,
  input wire nrst,
  input wire ce,
  // Monitored channels, three bits each
  input wire [CHANNELS*3-1:0] chan_sig,
  // Fault detectors, one-cycle pulses from monitor logic
  input wire flt_conflict,
  input wire flt_red,
  input wire [CHANNELS-1:0] flt_red_chan,
  input wire flt_cvm,
  input wire flt_24a,
  input wire flt_24b,
  input wire flt_clear,
  input wire [CHANNELS-1:0] flt_clear_chan,
  input wire flt_watch,
  input wire flt_dual,
  input wire fault_reset,
  // Retained latch from battery-backed store
  input wire retained_valid,
  input wire [`SMFD_MODE_W-1:0] retained_mode,
  input wire [CHANNELS*3-1:0] retained_sig,
  // Time of day and pushbuttons
  input wire [TIME_W-1:0] now_time,
  input wire set_btn_n,
  input wire select_btn_n,
  // Upper and lower panels
  output reg [`SMFD_PANEL_CH*3-1:0] upper_sig,
  output reg [`SMFD_MODE_W-1:0] upper_legend,
  output reg [(CHANNELS-`SMFD_PANEL_CH)*3-1:0] lower_sig,
  // Latch to retain across power loss
  output reg latched,
  output reg [`SMFD_MODE_W-1:0] latched_mode,
  output reg [CHANNELS*3-1:0] latched_sig,
  // Message log display
  output reg [`SMFD_SCR_W-1:0] log_screen,
  output reg [`SMFD_CUR_W-1:0] log_cursor,
  output reg [LOG_AW:0] log_count,
  output reg [TIME_W-1:0] log_time,
  output reg [`SMFD_MODE_W-1:0] log_mode
);

// ----------------------------------------------------------------
// Menu states
// ----------------------------------------------------------------
localparam [5:0] ST_TIME = 6'h01;
localparam [5:0] ST_COUNT = 6'h02;
localparam [5:0] ST_MAIN = 6'h04;
localparam [5:0] ST_PROG = 6'h08;
localparam [5:0] ST_MSG = 6'h10;
localparam [5:0] ST_SPARE = 6'h20;

// ----------------------------------------------------------------
// Buttons
// ----------------------------------------------------------------
wire set_press;
wire sel_press;

smfd_debounce #(
  .STABLE_CYCLES(DEBOUNCE_CYCLES)
) u_set (
  .mclk(mclk),
  .nrst(nrst),
  .ce(ce),
  .button_n(set_btn_n),
  .press(set_press)
);

smfd_debounce #(
  .STABLE_CYCLES(DEBOUNCE_CYCLES)
) u_sel (
  .mclk(mclk),
  .nrst(nrst),
  .ce(ce),
  .button_n(select_btn_n),
  .press(sel_press)
);

// ----------------------------------------------------------------
// Channel input synchroniser
// ----------------------------------------------------------------
reg [CHANNELS*3-1:0] sig_a;
reg [CHANNELS*3-1:0] sig_live;

always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    sig_a <= {CHANNELS*3{1'b0}};
    sig_live <= {CHANNELS*3{1'b0}};
  end
  else if (ce)
  begin
    sig_a <= chan_sig;
    sig_live <= sig_a;
  end
end

// ----------------------------------------------------------------
// Fault latch, priority encoded
// ----------------------------------------------------------------
reg [`SMFD_MODE_W-1:0] next_mode;
reg [CHANNELS*3-1:0] next_sig;
reg [CHANNELS-1:0] clear_chan;
reg restored;
integer i, k;

always @*
begin
  next_mode = `SMFD_MODE_NONE;
  next_sig = sig_live;
  if (flt_conflict)
    next_mode = `SMFD_MODE_CONF;
  else if (flt_red)
  begin
    next_mode = `SMFD_MODE_RED;
    for (i = 0; i < CHANNELS; i = i + 1)
      if (flt_red_chan[i])
        next_sig[i*3 +: 3] = 3'h0;
  end
  else if (flt_cvm)
    next_mode = `SMFD_MODE_CVM;
  else if (flt_24a)
    next_mode = `SMFD_MODE_24A;
  else if (flt_24b)
    next_mode = `SMFD_MODE_24B;
  else if (flt_clear)
    next_mode = `SMFD_MODE_CLEAR;
  else if (flt_watch)
    next_mode = `SMFD_MODE_WATCH;
  else if (flt_dual)
    next_mode = `SMFD_MODE_FAIL;
end

wire new_fault = (next_mode != `SMFD_MODE_NONE) && (!latched || fault_reset);

// Retained state is taken one cycle after reset release, never by the reset itself.
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    latched <= 1'b0;
    latched_mode <= `SMFD_MODE_NONE;
    latched_sig <= {CHANNELS*3{1'b0}};
    clear_chan <= {CHANNELS{1'b0}};
    restored <= 1'b0;
  end
  else if (ce)
  begin
    restored <= 1'b1;
    if (!restored && retained_valid)
    begin
      latched <= 1'b1;
      latched_mode <= retained_mode;
      latched_sig <= retained_sig;
    end
    else if (new_fault)
    begin
      latched <= 1'b1;
      latched_mode <= next_mode;
      latched_sig <= next_sig;
      clear_chan <= flt_clear_chan;
    end
    else if (fault_reset)
    begin
      latched <= 1'b0;
      latched_mode <= `SMFD_MODE_NONE;
      clear_chan <= {CHANNELS{1'b0}};
    end
  end
end

// ----------------------------------------------------------------
// Message log: circular buffer, newest at head - 1
// ----------------------------------------------------------------
reg [CHANNELS*3-1:0] mem_sig [0:LOG_DEPTH-1];
reg [`SMFD_MODE_W-1:0] mem_mode [0:LOG_DEPTH-1];
reg [TIME_W-1:0] mem_time [0:LOG_DEPTH-1];
reg [LOG_AW-1:0] head;
reg [LOG_AW-1:0] view;

always @(posedge mclk)
begin
  if (ce && new_fault)
  begin
    mem_sig[head] <= next_sig;
    mem_mode[head] <= next_mode;
    mem_time[head] <= now_time;
  end
end

// ----------------------------------------------------------------
// Menu machine
// ----------------------------------------------------------------
reg [5:0] state;
reg [LOG_AW:0] viewed;

always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    state <= ST_TIME;
    log_cursor <= `SMFD_CUR_FIRST;
    head <= {LOG_AW{1'b0}};
    view <= {LOG_AW{1'b0}};
    viewed <= {(LOG_AW+1){1'b0}};
    log_count <= {(LOG_AW+1){1'b0}};
  end
  else if (ce)
  begin
    if (new_fault)
    begin
      head <= head + 1'b1;
      if (log_count != LOG_DEPTH)
        log_count <= log_count + 1'b1;
    end
    case (state)
      ST_TIME:
        if (sel_press)
          state <= ST_COUNT;
      ST_COUNT:
        if (sel_press)
        begin
          state <= ST_MAIN;
          log_cursor <= `SMFD_CUR_FIRST;
        end
      ST_MAIN, ST_PROG:
        if (sel_press)
          log_cursor <= (log_cursor == `SMFD_CUR_PRIOR) ? `SMFD_CUR_FIRST
            : log_cursor + 1'b1;
        else if (set_press && log_cursor == `SMFD_CUR_PRIOR)
        begin
          state <= (state == ST_PROG) ? ST_MAIN : ST_TIME;
          log_cursor <= `SMFD_CUR_FIRST;
        end
        else if (set_press && log_cursor == `SMFD_CUR_ENTER)
        begin
          log_cursor <= `SMFD_CUR_FIRST;
          if (state == ST_MAIN)
            state <= ST_PROG;
          else if (log_count != 0)
          begin
            state <= ST_MSG;
            view <= head - 1'b1;
            viewed <= {{LOG_AW{1'b0}}, 1'b1};
          end
        end
      ST_MSG:
        if (set_press)
          state <= ST_PROG;
        else if (sel_press && viewed < log_count)
        begin
          view <= view - 1'b1;
          viewed <= viewed + 1'b1;
        end
      default:
        state <= ST_TIME;
    endcase
  end
end

// ----------------------------------------------------------------
// Clearance marker flasher
// ----------------------------------------------------------------
reg [31:0] flash_cnt;
reg flash_on;

always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    flash_cnt <= 32'h0;
    flash_on <= 1'b0;
  end
  else if (ce)
  begin
    if (flash_cnt >= FLASH_CYCLES - 1)
    begin
      flash_cnt <= 32'h0;
      flash_on <= ~flash_on;
    end
    else
      flash_cnt <= flash_cnt + 32'h1;
  end
end

// ----------------------------------------------------------------
// Panel outputs
// ----------------------------------------------------------------
reg [CHANNELS*3-1:0] show_sig;
reg [`SMFD_MODE_W-1:0] show_mode;

always @*
begin
  show_sig = sig_live;
  show_mode = `SMFD_MODE_NONE;
  if (state == ST_MSG)
  begin
    show_sig = mem_sig[view];
    show_mode = mem_mode[view];
  end
  else if (latched)
  begin
    show_sig = latched_sig;
    show_mode = latched_mode;
    if (latched_mode == `SMFD_MODE_CLEAR)
      for (k = 0; k < CHANNELS; k = k + 1)
        if (clear_chan[k] && flash_on)
          show_sig[k*3 +: 3] = `SMFD_SIG_RED;
  end
end

// Display data is registered so the panels never see decode glitches.
always @(posedge mclk or negedge nrst)
begin
  if (!nrst)
  begin
    upper_sig <= {`SMFD_PANEL_CH*3{1'b0}};
    lower_sig <= {(CHANNELS-`SMFD_PANEL_CH)*3{1'b0}};
    upper_legend <= `SMFD_MODE_NONE;
    log_screen <= `SMFD_SCR_TIME;
    log_time <= {TIME_W{1'b0}};
    log_mode <= `SMFD_MODE_NONE;
  end
  else if (ce)
  begin
    upper_sig <= show_sig[`SMFD_PANEL_CH*3-1:0];
    lower_sig <= show_sig[CHANNELS*3-1:`SMFD_PANEL_CH*3];
    upper_legend <= show_mode;
    log_time <= now_time;
    log_mode <= `SMFD_MODE_NONE;
    case (state)
      ST_TIME:
        if (latched && log_count != 0)
        begin
          log_screen <= `SMFD_SCR_EVENT;
          log_time <= mem_time[head - 1'b1];
          log_mode <= mem_mode[head - 1'b1];
        end
        else
          log_screen <= `SMFD_SCR_TIME;
      ST_COUNT:
        log_screen <= `SMFD_SCR_COUNT;
      ST_MAIN:
        log_screen <= `SMFD_SCR_MAIN;
      ST_PROG:
        log_screen <= `SMFD_SCR_PROG;
      ST_MSG:
      begin
        log_screen <= `SMFD_SCR_MSG;
        log_time <= mem_time[view];
        log_mode <= mem_mode[view];
      end
      default:
        log_screen <= `SMFD_SCR_TIME;
    endcase
  end
end

endmodule // smfd_display

//--- tb/smfd_display_properties.sv
// Port checker of the fault display block.
`timescale 1ns/100ps
module smfd_display_properties (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Inputs watched
  input wire ce,
  input wire [35:0] chan_sig,
  input wire flt_conflict,
  input wire fault_reset,
  // Outputs watched
  input wire [17:0] upper_sig,
  input wire [3:0] upper_legend,
  input wire [17:0] lower_sig,
  input wire latched,
  input wire [3:0] latched_mode,
  input wire [35:0] latched_sig,
  input wire [2:0] log_screen,
  input wire [4:0] log_count
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence s_held;
    (ce && latched && !fault_reset && log_screen != 3'h4)[*2];
  endsequence
  sequence s_live;
    (ce && !latched && log_screen == 3'h0)[*4];
  endsequence
  a_conf_latch: assert property (ce && !latched && flt_conflict |=> latched_mode == 4'h1)
    else $error("conflict not latched");
  a_legend_held: assert property (s_held |-> upper_legend == latched_mode)
    else $error("legend differs from latch");
  a_frozen_conf: assert property (s_held ##0 latched_mode == 4'h1 |->
    {lower_sig, upper_sig} == latched_sig)
    else $error("panels not frozen");
  a_live_panels: assert property (s_live |-> {lower_sig, upper_sig} == $past(chan_sig, 3))
    else $error("panels not live");
  a_count_step: assert property (ce && !latched && flt_conflict && log_count < 5'h10 |=>
    log_count == $past(log_count) + 5'h1)
    else $error("log count not stepped");
  a_latch_holds: assert property (latched && !fault_reset |=> latched)
    else $error("latch dropped");
  a_time_next: assert property (log_screen == 3'h0 ##1 log_screen != 3'h0 |->
    log_screen inside {3'h1, 3'h5})
    else $error("bad screen after time");
  a_count_next: assert property ($past(log_screen) == 3'h1 && log_screen != 3'h1 |->
    log_screen inside {3'h2, 3'h5})
    else $error("bad screen after count");
  a_msg_exit: assert property (log_screen == 3'h4 ##1 log_screen != 3'h4 |->
    log_screen == 3'h3)
    else $error("bad exit from messages");
endmodule // smfd_display_properties

bind smfd_display smfd_display_properties chk_i (.mclk, .nrst, .ce, .chan_sig, .flt_conflict,
  .fault_reset, .upper_sig, .upper_legend, .lower_sig, .latched, .latched_mode, .latched_sig,
  .log_screen, .log_count);

//--- tb/smfd_far.sv
// Model of the monitored channels and the operator pushbuttons.
`timescale 1ns/100ps
module smfd_far (
  // Clock
  input wire mclk,
  // Toward the block
  output logic [35:0] chan_sig,
  output logic set_btn_n,
  output logic select_btn_n
);
  // ------------------------------------------------------------
  // Pushbuttons
  // ------------------------------------------------------------
  initial
  begin
    chan_sig = 36'h0;
    set_btn_n = 1'b1;
    select_btn_n = 1'b1;
  end
  // Contacts chatter on make and break; buttons idle at the pull-up level.
  task press(input bit sel);
    integer j;
    logic v;
    for (j = 0; j < 40; j++)
    begin
      @(negedge mclk);
      v = (j < 4 || (j >= 20 && j < 24)) ? j[0] : (j >= 20);
      if (sel)
        select_btn_n = v;
      else
        set_btn_n = v;
    end
  endtask
endmodule // smfd_far

//--- tb/testbench.sv
// Self-checking bench of the fault display block.
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] flt = 8'h0;
  logic fault_reset = 1'b0;
  logic ret_v = 1'b0;
  logic [3:0] ret_m = 4'h0;
  logic [35:0] ret_s = 36'h0;
  logic [31:0] now_time = 32'h0;
  wire [35:0] chan_sig;
  wire set_btn_n, select_btn_n, latched;
  wire [17:0] upper_sig, lower_sig;
  wire [3:0] upper_legend, latched_mode, log_mode;
  wire [35:0] latched_sig;
  wire [2:0] log_screen;
  wire [1:0] log_cursor;
  wire [4:0] log_count;
  wire [31:0] log_time;
  wire [35:0] pan = {lower_sig, upper_sig};
  logic ce = 1'b1;
  logic [11:0] fch = 12'h020;
  logic [35:0] hold;
  integer errors = 0, n_tests = 0, seed = 20, i;
  logic [3:0] q_m[$];
  logic [35:0] q_s[$];
  logic [31:0] q_t[$];

  always #2 mclk = ~mclk;
  smfd_far far (.mclk, .chan_sig, .set_btn_n, .select_btn_n);
  smfd_display #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(4)) dut (.mclk, .nrst, .ce,
    .chan_sig, .flt_conflict(flt[0]), .flt_red(flt[1]), .flt_red_chan(fch),
    .flt_cvm(flt[2]), .flt_24a(flt[3]), .flt_24b(flt[4]), .flt_clear(flt[5]),
    .flt_clear_chan(fch), .flt_watch(flt[6]), .flt_dual(flt[7]), .fault_reset,
    .retained_valid(ret_v), .retained_mode(ret_m), .retained_sig(ret_s), .now_time,
    .set_btn_n, .select_btn_n, .upper_sig, .upper_legend, .lower_sig, .latched,
    .latched_mode, .latched_sig, .log_screen, .log_cursor, .log_count, .log_time, .log_mode);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [35:0] g, input logic [35:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task pulse(input integer k);
    flt[k] = 1'b1;
    cyc(1);
    flt[k] = 1'b0;
    cyc(2);
  endtask
  task clr;
    fault_reset = 1'b1;
    cyc(1);
    fault_reset = 1'b0;
    cyc(4);
  endtask
  // Captured pattern keeps a green on a random channel so blanking and flashing show.
  task fault(input integer k);
    logic [35:0] s;
    logic [1:0] seen;
    integer j, c;
    c = $unsigned($random(seed)) % 12;
    fch = 12'h1 << c;
    s = {$random(seed), $random(seed)};
    s[c*3 +: 3] = 3'h1;
    far.chan_sig = s;
    now_time = $random(seed);
    cyc(4);
    pulse(k);
    q_m.push_front(k + 1);
    q_s.push_front(s);
    q_t.push_front(now_time);
    far.chan_sig = ~s;
    cyc(3);
    chk(latched_mode, k + 1);
    chk(upper_legend, k + 1);
    chk(log_count, q_m.size());
    chk(log_screen, 3'h5);
    chk(log_time, now_time);
    seen = 2'h0;
    for (j = 0; j < 12 && k == 5; j++)
    begin
      cyc(1);
      seen[pan[c*3 +: 3] === 3'h4] = 1'b1;
    end
    if (k == 1)
      chk(pan, s & ~(36'h7 << (c*3)));
    else if (k == 5)
      chk(seen, 2'h3);
    else
      chk({lower_sig, upper_sig}, s);
    pulse(0);
    chk(log_count, q_m.size());
    clr;
    chk(latched, 1'b0);
    chk(log_screen, 3'h0);
  endtask
  task cur(input logic [1:0] c);
    integer j;
    for (j = 0; j < 3 && log_cursor !== c; j++)
      far.press(1);
    chk(log_cursor, c);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    #100000;
    errors++;
    wrap_up;
  end
  initial
  begin
    cyc(10);
    nrst = 1'b1;
    cyc(2);
    chk(log_screen, 3'h0);
    for (i = 0; i < 3; i++)
    begin
      far.chan_sig = {$random(seed), $random(seed)};
      cyc(4);
      chk({lower_sig, upper_sig}, far.chan_sig);
    end
    hold = pan;
    ce = 1'b0;
    far.chan_sig = ~hold;
    cyc(6);
    chk(pan, hold);
    ce = 1'b1;
    cyc(4);
    chk(pan, ~hold);
    $display("live test done");
    for (i = 0; i < 8; i++)
      fault(i);
    $display("fault test done");
    far.press(1);
    chk(log_screen, 3'h1);
    chk(log_count, q_m.size());
    far.press(1);
    chk(log_screen, 3'h2);
    cur(1);
    far.press(0);
    chk(log_screen, 3'h3);
    cur(1);
    far.press(0);
    chk(log_screen, 3'h4);
    for (i = 0; i < 3; i++)
    begin
      chk(log_time, q_t[i]);
      chk(log_mode, q_m[i]);
      chk(upper_legend, q_m[i]);
      if (i < 2)
        chk({lower_sig, upper_sig}, q_s[i]);
      far.press(1);
    end
    pulse(6);
    chk(latched, 1'b1);
    clr;
    far.press(0);
    chk(log_screen, 3'h3);
    cur(2);
    far.press(0);
    chk(log_screen, 3'h2);
    cur(2);
    far.press(0);
    chk(log_screen, 3'h0);
    $display("menu test done");
    ret_v = 1'b1;
    ret_m = 4'h7;
    ret_s = {$random(seed), $random(seed)};
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(5);
    chk(latched, 1'b1);
    chk(upper_legend, ret_m);
    chk({lower_sig, upper_sig}, ret_s);
    $display("power test done");
    wrap_up;
  end
endmodule // testbench
